// File: hdl/fpm_pkg.sv
// package of constants and types for the front-panel menu controller
package fpm_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
    localparam int DEB_MS = 20;
    localparam int PHASE_MS = 1000;
    localparam int BLINK_MS = 250;
    localparam int MENU_HOLD_MS = 2000;
    localparam int SP_CONFIRM_S = 30;
    localparam int MENU_IDLE_S = 30;
    localparam int EDIT_IDLE_S = 30;
    localparam logic [4:0] DEB_TICKS = 5'(DEB_MS * 1000 / TICK_US);
    localparam logic [9:0] PHASE_TICKS = 10'(PHASE_MS * 1000 / TICK_US);
    localparam logic [7:0] BLINK_TICKS = 8'(BLINK_MS * 1000 / TICK_US);
    localparam logic [10:0] HOLD_TICKS = 11'(MENU_HOLD_MS * 1000 / TICK_US);
    localparam logic [14:0] SP_IDLE_TICKS = 15'(SP_CONFIRM_S * 1_000_000 / TICK_US);
    localparam logic [14:0] MENU_IDLE_TICKS = 15'(MENU_IDLE_S * 1_000_000 / TICK_US);
    localparam logic [14:0] EDIT_IDLE_TICKS = 15'(EDIT_IDLE_S * 1_000_000 / TICK_US);
    localparam logic [14:0] IDLE_MAX = 15'h7FFF;

    // ----------------------------------------------------------------
    // menu shape
    // ----------------------------------------------------------------
    localparam logic [2:0] NUM_LEVELS = 3'h4;
    localparam logic [2:0] NUM_PARAMS = 3'h4;
    localparam logic [2:0] EXIT_POS = 3'h4;

    // ----------------------------------------------------------------
    // register offsets and layout
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETPOINT = 8'h04;
    localparam logic [7:0] OFS_SP_LIMITS = 8'h08;
    localparam logic [7:0] OFS_ACCESS = 8'h0C;
    localparam logic [7:0] OFS_PARAM_VIS = 8'h10;
    localparam logic [7:0] OFS_PID_A = 8'h14;
    localparam logic [7:0] OFS_PID_B = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_PARAM_BASE = 8'h40;
    localparam int CTRL_ONOFF_BIT = 0;
    localparam int CTRL_FAULT_LSB = 8;
    localparam int PID_B_PERIOD_LSB = 16;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PB_RST = 16'h001E;
    localparam logic [15:0] TI_RST = 16'h012C;
    localparam logic [15:0] TD_RST = 16'h003C;
    localparam logic [7:0] PERIOD_RST = 8'h14;
    localparam logic [15:0] SP_RST = 16'h0064;
    localparam logic [15:0] SPL_RST = 16'h0000;
    localparam logic [15:0] SPH_RST = 16'h03E8;
    localparam logic [15:0] VIS_RST = 16'hFFFF;
    // identity values are arbitrary
    localparam logic [15:0] IDENT_CODE = 16'hA5A5;
    localparam logic [15:0] VERSION_CODE = 16'h0100;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic up;
        logic down;
        logic enter;
        logic menu;
    } fpm_btn_t;

    typedef enum logic [3:0] {
        DK_TEST = 4'h0,
        DK_IDENT = 4'h1,
        DK_VERSION = 4'h2,
        DK_VALUES = 4'h3,
        DK_MESSAGE = 4'h4,
        DK_CODE = 4'h5,
        DK_LEVEL = 4'h6,
        DK_PARAM = 4'h7,
        DK_VALUE = 4'h8,
        DK_EXIT = 4'h9
    } fpm_kind_t;

    typedef struct packed {
        fpm_kind_t kind;
        logic [15:0] upper;
        logic [15:0] lower;
        logic dot;
    } fpm_disp_t;

    typedef enum logic [2:0] {
        ST_TEST = 3'b000,
        ST_IDENT = 3'b001,
        ST_VERSION = 3'b011,
        ST_NORMAL = 3'b010,
        ST_CODE = 3'b110,
        ST_LEVELS = 3'b111,
        ST_PARAMS = 3'b101,
        ST_EDIT = 3'b100
    } fpm_state_t;
endpackage

// File: hdl/fpm_tick.sv
// divider that makes the one-millisecond tick enable
`timescale 1ns/100ps
module fpm_tick import fpm_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // enable out
    output logic tick
);
    localparam int CW = $clog2(TICK_CYC + 1);
    logic [CW-1:0] cnt_ff;
    logic tick_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == CW'(TICK_CYC - 1)) begin
            cnt_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule

// File: hdl/fpm_debounce.sv
// push-button debouncer: stable levels and one-cycle press pulses
`timescale 1ns/100ps
module fpm_debounce import fpm_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    // raw buttons, active high
    input fpm_btn_t btn_raw,
    // cleaned buttons
    output fpm_btn_t btn_lvl,
    output fpm_btn_t btn_press
);
    logic [3:0] raw;
    logic [3:0] lvl_ff;
    logic [3:0] press_ff;

    assign raw = btn_raw;

    for (genvar i = 0; i < 4; i++) begin : g_btn
        logic [4:0] cnt_ff;
        // a level must hold for the whole window before it is believed
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cnt_ff <= '0;
                lvl_ff[i] <= 1'b0;
                press_ff[i] <= 1'b0;
            end else begin
                press_ff[i] <= 1'b0;
                if (raw[i] == lvl_ff[i]) begin
                    cnt_ff <= '0;
                end else if (tick) begin
                    if (cnt_ff == DEB_TICKS - 5'h01) begin
                        cnt_ff <= '0;
                        lvl_ff[i] <= raw[i];
                        press_ff[i] <= raw[i];
                    end else begin
                        cnt_ff <= cnt_ff + 5'h01;
                    end
                end
            end
        end
    end

    assign btn_lvl = lvl_ff;
    assign btn_press = press_ff;
endmodule

// File: hdl/fpm_top.sv
// front-panel operating logic: power-up, quick set point, menu, registers
//
// Notes on behaviour
// - power-up shows display test, identification, version, then normal values
// - nonzero fault code replaces normal display with a message
// - first use selects PID with 30, 300 s, 60 s, 20 s defaults
// - adjust buttons in normal mode start a change; lower dot flashes
// - confirm within 30 s of last adjust applies, else old value returns
// - quick adjust keeps set point between lower and upper limits
// - menu button held about 2 s in normal mode enters menu
// - wrong access code permits viewing but rejects every change
// - step and select levels; adjust steps parameters; edit per procedure
// - exit symbol in a level plus select returns to level list
// - exit symbol in level list plus select returns to normal mode
// - parameters hidden by configuration are skipped while stepping
// - thirty seconds without a press in menu returns to normal mode
// - edit cancelled by both adjust buttons or 30 s idle
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module fpm_top import fpm_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // front panel
    input fpm_btn_t btn_raw,
    input wire logic [15:0] pv,
    output fpm_disp_t disp,
    output logic [15:0] sp_active
);
    // ----------------------------------------------------------------
    // tick and buttons
    // ----------------------------------------------------------------
    logic tick;
    fpm_btn_t lvl;
    fpm_btn_t prs;

    fpm_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .mclk(mclk),
        .rst(rst),
        .tick(tick)
    );

    fpm_debounce u_deb (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .btn_raw(btn_raw),
        .btn_lvl(lvl),
        .btn_press(prs)
    );

    logic any_press;
    logic both;
    logic step_up;
    logic step_dn;
    assign any_press = prs.up | prs.down | prs.enter | prs.menu;
    assign both = lvl.up & lvl.down & (prs.up | prs.down);
    assign step_up = prs.up & ~lvl.down;
    assign step_dn = prs.down & ~lvl.up;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    fpm_state_t state_ff;
    logic [2:0] lvl_idx_ff;
    logic [2:0] par_idx_ff;
    logic [15:0] code_val_ff;
    logic edit_ok_ff;
    logic [15:0] edit_val_ff;
    logic [15:0] sp_ff;
    logic [15:0] sp_pend_ff;
    logic pend_ff;
    logic [15:0] spl_ff;
    logic [15:0] sph_ff;
    logic [15:0] access_ff;
    logic [15:0] vis_ff;
    logic [15:0] pb_ff;
    logic [15:0] ti_ff;
    logic [15:0] td_ff;
    logic [7:0] period_ff;
    logic onoff_ff;
    logic [7:0] fault_ff;
    logic [15:0] param_mem [16];
    logic [14:0] idle_ff;
    logic [10:0] hold_ff;
    logic [9:0] phase_ff;
    logic [7:0] blink_cnt_ff;
    logic blink_ff;

    logic in_menu;
    logic phase_done;
    logic hold_fire;
    logic sp_timeout;
    logic menu_timeout;
    logic [3:0] par_addr;
    assign in_menu = state_ff[2];
    assign phase_done = tick & (phase_ff == PHASE_TICKS - 10'h001);
    assign hold_fire = tick & lvl.menu & (hold_ff == HOLD_TICKS - 11'h001);
    assign sp_timeout = tick & (idle_ff == SP_IDLE_TICKS - 15'h0001);
    assign menu_timeout = tick & ((idle_ff == MENU_IDLE_TICKS - 15'h0001) |
        (state_ff == ST_EDIT && idle_ff == EDIT_IDLE_TICKS - 15'h0001));
    assign par_addr = {lvl_idx_ff[1:0], par_idx_ff[1:0]};

    // next shown position, skipping parameters hidden in this level
    function automatic logic [2:0] nxt_vis(input logic [2:0] idx, input logic up,
        input logic [1:0] lv, input logic [15:0] mask);
        logic [2:0] c;
        logic found;
        logic [2:0] res;
        c = idx;
        found = 1'b0;
        res = EXIT_POS;
        for (int i = 0; i <= 4; i++) begin
            if (up) begin
                c = (c == EXIT_POS) ? 3'h0 : c + 3'h1;
            end else begin
                c = (c == 3'h0) ? EXIT_POS : c - 3'h1;
            end
            if (!found && (c == EXIT_POS || mask[{lv, c[1:0]}])) begin
                res = c;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    function automatic logic [15:0] clamp(input logic [16:0] v, input logic [15:0] lo,
        input logic [15:0] hi);
        if (v[16] || v[15:0] > hi) begin
            return hi;
        end else if (v[15:0] < lo) begin
            return lo;
        end
        return v[15:0];
    endfunction

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_ff <= '0;
            hold_ff <= '0;
            phase_ff <= '0;
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else begin
            if (any_press) begin
                idle_ff <= '0;
            end else if (tick && idle_ff != IDLE_MAX) begin
                idle_ff <= idle_ff + 15'h0001;
            end
            if (state_ff != ST_NORMAL || !lvl.menu) begin
                hold_ff <= '0;
            end else if (tick && hold_ff != HOLD_TICKS) begin
                hold_ff <= hold_ff + 11'h001;
            end
            if (phase_done) begin
                phase_ff <= '0;
            end else if (tick) begin
                phase_ff <= phase_ff + 10'h001;
            end
            if (tick) begin
                if (blink_cnt_ff == BLINK_TICKS - 8'h01) begin
                    blink_cnt_ff <= '0;
                    blink_ff <= ~blink_ff;
                end else begin
                    blink_cnt_ff <= blink_cnt_ff + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // operating state and navigation
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_TEST;
            lvl_idx_ff <= '0;
            par_idx_ff <= '0;
            code_val_ff <= '0;
            edit_ok_ff <= 1'b0;
        end else if (in_menu && menu_timeout) begin
            state_ff <= ST_NORMAL;
            edit_ok_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_TEST: if (phase_done) state_ff <= ST_IDENT;
                ST_IDENT: if (phase_done) state_ff <= ST_VERSION;
                ST_VERSION: if (phase_done) state_ff <= ST_NORMAL;
                ST_NORMAL: begin
                    if (hold_fire) begin
                        lvl_idx_ff <= '0;
                        code_val_ff <= '0;
                        edit_ok_ff <= (access_ff == 16'h0000);
                        state_ff <= (access_ff == 16'h0000) ? ST_LEVELS : ST_CODE;
                    end
                end
                ST_CODE: begin
                    if (step_up) code_val_ff <= code_val_ff + 16'h0001;
                    if (step_dn) code_val_ff <= code_val_ff - 16'h0001;
                    if (prs.enter) begin
                        edit_ok_ff <= (code_val_ff == access_ff);
                        state_ff <= ST_LEVELS;
                    end
                end
                ST_LEVELS: begin
                    if (step_up) lvl_idx_ff <= (lvl_idx_ff == EXIT_POS) ? 3'h0 : lvl_idx_ff + 3'h1;
                    if (step_dn) lvl_idx_ff <= (lvl_idx_ff == 3'h0) ? EXIT_POS : lvl_idx_ff - 3'h1;
                    if (prs.enter && lvl_idx_ff == EXIT_POS) begin
                        state_ff <= ST_NORMAL;
                        edit_ok_ff <= 1'b0;
                    end else if (prs.enter) begin
                        par_idx_ff <= nxt_vis(EXIT_POS, 1'b1, lvl_idx_ff[1:0], vis_ff);
                        state_ff <= ST_PARAMS;
                    end
                end
                ST_PARAMS: begin
                    if (step_up) par_idx_ff <= nxt_vis(par_idx_ff, 1'b1, lvl_idx_ff[1:0], vis_ff);
                    if (step_dn) par_idx_ff <= nxt_vis(par_idx_ff, 1'b0, lvl_idx_ff[1:0], vis_ff);
                    if (prs.enter) begin
                        state_ff <= (par_idx_ff == EXIT_POS) ? ST_LEVELS : ST_EDIT;
                    end
                end
                ST_EDIT: begin
                    if (both || prs.enter) state_ff <= ST_PARAMS;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // parameter edit and store
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            edit_val_ff <= '0;
            for (int i = 0; i < 16; i++) begin
                param_mem[i] <= '0;
            end
        end else if (state_ff == ST_PARAMS && prs.enter) begin
            edit_val_ff <= param_mem[par_addr];
        end else if (state_ff == ST_EDIT && !menu_timeout && !both) begin
            // without permission the value is shown but never moves
            if (edit_ok_ff && step_up) edit_val_ff <= edit_val_ff + 16'h0001;
            if (edit_ok_ff && step_dn) edit_val_ff <= edit_val_ff - 16'h0001;
            if (edit_ok_ff && prs.enter) param_mem[par_addr] <= edit_val_ff;
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic acc;
    logic wr_ph_ff;
    logic rd_ph_ff;
    logic [7:0] addr_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    logic bus_wr;
    assign acc = hsel & htrans[1] & hready;
    assign bus_wr = wr_ph_ff;
    // reads take one wait state so that read data come from a flop
    assign hreadyout = ~rd_ph_ff;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;

    always_comb begin
        rd_mux = '0;
        if (addr_ff >= OFS_PARAM_BASE && addr_ff < OFS_PARAM_BASE + 8'h40) begin
            rd_mux = {16'h0000, param_mem[addr_ff[5:2]]};
        end else begin
            unique case (addr_ff)
                OFS_CTRL: rd_mux = {16'h0000, fault_ff, 7'h00, onoff_ff};
                OFS_SETPOINT: rd_mux = {16'h0000, sp_ff};
                OFS_SP_LIMITS: rd_mux = {sph_ff, spl_ff};
                OFS_ACCESS: rd_mux = {16'h0000, access_ff};
                OFS_PARAM_VIS: rd_mux = {16'h0000, vis_ff};
                OFS_PID_A: rd_mux = {ti_ff, pb_ff};
                OFS_PID_B: rd_mux = {8'h00, period_ff, td_ff};
                OFS_STATUS: rd_mux = {16'h0000, sp_pend_ff[7:0], par_idx_ff[1:0],
                    lvl_idx_ff[0], edit_ok_ff, pend_ff, state_ff};
                default: rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ph_ff <= 1'b0;
            rd_ph_ff <= 1'b0;
            addr_ff <= '0;
            rdata_ff <= '0;
        end else begin
            wr_ph_ff <= acc & hwrite;
            rd_ph_ff <= acc & ~hwrite;
            if (acc) addr_ff <= {haddr[7:2], 2'b00};
            if (rd_ph_ff) rdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            onoff_ff <= 1'b0;
            fault_ff <= '0;
            spl_ff <= SPL_RST;
            sph_ff <= SPH_RST;
            access_ff <= '0;
            vis_ff <= VIS_RST;
            pb_ff <= PB_RST;
            ti_ff <= TI_RST;
            td_ff <= TD_RST;
            period_ff <= PERIOD_RST;
        end else if (bus_wr) begin
            unique case (addr_ff)
                OFS_CTRL: begin
                    onoff_ff <= hwdata[CTRL_ONOFF_BIT];
                    fault_ff <= hwdata[CTRL_FAULT_LSB +: 8];
                end
                OFS_SP_LIMITS: {sph_ff, spl_ff} <= hwdata;
                OFS_ACCESS: access_ff <= hwdata[15:0];
                OFS_PARAM_VIS: vis_ff <= hwdata[15:0];
                OFS_PID_A: {ti_ff, pb_ff} <= hwdata;
                OFS_PID_B: begin
                    td_ff <= hwdata[15:0];
                    period_ff <= hwdata[PID_B_PERIOD_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // quick set point change
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_ff <= SP_RST;
            sp_pend_ff <= SP_RST;
            pend_ff <= 1'b0;
        end else if (bus_wr && addr_ff == OFS_SETPOINT) begin
            sp_ff <= hwdata[15:0];
            pend_ff <= 1'b0;
        end else if (state_ff != ST_NORMAL || sp_timeout) begin
            pend_ff <= 1'b0;
        end else if (step_up || step_dn) begin
            pend_ff <= 1'b1;
            sp_pend_ff <= clamp(step_up ? {1'b0, pend_ff ? sp_pend_ff : sp_ff} + 17'h0_0001
                : {1'b0, pend_ff ? sp_pend_ff : sp_ff} - 17'h0_0001, spl_ff, sph_ff);
        end else if (prs.enter && pend_ff) begin
            sp_ff <= sp_pend_ff;
            pend_ff <= 1'b0;
        end
    end

    assign sp_active = sp_ff;

    // ----------------------------------------------------------------
    // display
    // ----------------------------------------------------------------
    fpm_disp_t disp_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            disp_ff <= '{kind: DK_TEST, upper: 16'hFFFF, lower: 16'hFFFF, dot: 1'b1};
        end else begin
            disp_ff.dot <= 1'b0;
            unique case (state_ff)
                ST_TEST: disp_ff <= '{DK_TEST, 16'hFFFF, 16'hFFFF, 1'b1};
                ST_IDENT: disp_ff <= '{DK_IDENT, IDENT_CODE, 16'h0000, 1'b0};
                ST_VERSION: disp_ff <= '{DK_VERSION, VERSION_CODE, 16'h0000, 1'b0};
                ST_NORMAL: begin
                    disp_ff.kind <= (fault_ff != 8'h00) ? DK_MESSAGE : DK_VALUES;
                    disp_ff.upper <= (fault_ff != 8'h00) ? {8'h00, fault_ff} : pv;
                    disp_ff.lower <= pend_ff ? sp_pend_ff : sp_ff;
                    disp_ff.dot <= pend_ff & blink_ff;
                end
                ST_CODE: disp_ff <= '{DK_CODE, 16'h0000, code_val_ff, 1'b0};
                ST_LEVELS: disp_ff <= '{(lvl_idx_ff == EXIT_POS) ? DK_EXIT : DK_LEVEL,
                    {13'h0000, lvl_idx_ff}, 16'h0000, 1'b0};
                ST_PARAMS: disp_ff <= '{(par_idx_ff == EXIT_POS) ? DK_EXIT : DK_PARAM,
                    {12'h000, par_addr}, param_mem[par_addr], 1'b0};
                ST_EDIT: disp_ff <= '{DK_VALUE, {12'h000, par_addr}, edit_val_ff,
                    edit_ok_ff & blink_ff};
            endcase
        end
    end

    assign disp = disp_ff;
endmodule

// File: sim/fpm_chk_props.sv
// checker of bus timing and power-up display order
`timescale 1ns/100ps
module fpm_chk import fpm_pkg::*; (
    // clock, reset, bus
    input wire logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hrdata,
    // panel
    input fpm_disp_t disp
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic rd, wr;
    fpm_kind_t k;
    assign rd = hsel && htrans[1] && hready && !hwrite;
    assign wr = hsel && htrans[1] && hready && hwrite;
    assign k = disp.kind;
    resp_okay_a: assert property (hresp == 1'b0) else $error("bad resp");
    rd_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait");
    wr_no_wait_a: assert property (wr |=> hreadyout) else $error("write wait");
    rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved");
    test_then_ident_a: assert property ($changed(k) && $past(k) == DK_TEST |-> k == DK_IDENT)
        else $error("after test");
    ident_then_ver_a: assert property ($changed(k) && $past(k) == DK_IDENT |-> k == DK_VERSION)
        else $error("after ident");
    ver_then_vals_a: assert property ($changed(k) && $past(k) == DK_VERSION |->
        k inside {DK_VALUES, DK_MESSAGE}) else $error("after version");
    ident_code_a: assert property (k == DK_IDENT |-> disp.upper == IDENT_CODE)
        else $error("ident value");
    rd_c: cover property (rd);
    level_c: cover property (k == DK_LEVEL);
    pend_c: cover property (k == DK_VALUES && disp.dot);
endmodule
bind fpm_top fpm_chk i_chk (.mclk(mclk), .rst(rst), .hsel(hsel), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans),
    .hrdata(hrdata), .disp(disp));

// File: sim/fpm_panel.sv
// operator push-button model
`timescale 1ns/100ps
module fpm_panel import fpm_pkg::*; (
    // clock
    input wire logic mclk,
    // buttons to the device
    output fpm_btn_t btn
);
    initial btn = '0;
    // released long past the debounce span so each press counts once
    task automatic push(input int b, input int n);
        @(posedge mclk) btn[b] <= 1'b1;
        repeat (n) @(posedge mclk);
        btn[b] <= 1'b0;
        repeat (80) @(posedge mclk);
    endtask
endmodule

// File: sim/front_panel_menu_control_tb_top.sv
// self-checking bench for the front-panel menu controller
`timescale 1ns/100ps
module front_panel_menu_control_tb_top import fpm_pkg::*;;
    logic mclk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [15:0] pv = '0, sp_active, sp, rnd = 16'h7c68;
    fpm_btn_t btn;
    fpm_disp_t disp;
    int n_errors = 0, checked = 0;
    always #5 mclk = ~mclk;
    assign hready = hreadyout;
    fpm_top #(.TICK_CYC(1)) i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .btn_raw(btn), .pv(pv),
        .disp(disp), .sp_active(sp_active));
    fpm_panel i_pnl (.mclk(mclk), .btn(btn));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] clamp(input logic [15:0] v, lo, hi);
        return (v > hi) ? hi : (v < lo) ? lo : v;
    endfunction
    task automatic chk(input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(a);
        do @(posedge mclk); while (!hreadyout);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (!hreadyout);
        rd = hrdata;
    endtask
    task automatic finish_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        chk(disp.kind, DK_TEST);
        chk(sp_active, SP_RST);
        rst <= 1'b0;
        bus(0, OFS_PID_A, '0);
        chk(rd, {TI_RST, PB_RST});
        bus(0, OFS_PID_B, '0);
        chk(rd, {8'h00, PERIOD_RST, TD_RST});
        bus(0, OFS_CTRL, '0);
        chk(rd, '0);
        bus(0, 8'h30, '0);
        chk(rd, '0);
        $display("register test done");
        rnd = lfsr(rnd);
        pv <= rnd;
        for (int i = 0; i < 9000 && disp.kind !== DK_VALUES; i++) @(posedge mclk);
        chk(disp.kind, DK_VALUES);
        chk(disp.upper, pv);
        rnd = lfsr(rnd);
        sp = 16'(rnd % 16'h0384) + 16'h0032;
        bus(1, OFS_SETPOINT, 32'(sp));
        bus(1, OFS_SP_LIMITS, {sp, 16'h0000});
        i_pnl.push(3, 60);
        chk(disp.lower, clamp(sp + 16'h0001, '0, sp));
        i_pnl.push(1, 60);
        chk(sp_active, sp);
        bus(1, OFS_SP_LIMITS, {sp + 16'h0005, 16'h0000});
        i_pnl.push(3, 60);
        chk(disp.lower, clamp(sp + 16'h0001, '0, sp + 16'h0005));
        chk(sp_active, sp);
        i_pnl.push(1, 60);
        chk(sp_active, sp + 16'h0001);
        i_pnl.push(2, 60);
        chk(disp.lower, sp);
        repeat (30000) @(posedge mclk);
        chk(disp.lower, sp + 16'h0001);
        chk(sp_active, sp + 16'h0001);
        bus(1, OFS_CTRL, 32'h0000_0500);
        repeat (2) @(posedge mclk);
        chk(disp.kind, DK_MESSAGE);
        chk(disp.upper, 32'h0000_0005);
        bus(1, OFS_CTRL, '0);
        repeat (2) @(posedge mclk);
        $display("set point test done");
        i_pnl.push(0, 4100);
        chk(disp.kind, DK_LEVEL);
        repeat (4) i_pnl.push(3, 60);
        chk(disp.kind, DK_EXIT);
        i_pnl.push(1, 60);
        chk(disp.kind, DK_VALUES);
        $display("menu test done");
        finish_test();
    end
    // the sequence needs about 38000 cycles, most of it the confirm window
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        finish_test();
    end
endmodule
